// >>> rtl/irq_prio_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module irq_prio_ctrl #(
   parameter int NSRC = irq_prio_pkg::NUM_SRC,
   parameter int NPIN = irq_prio_pkg::NUM_PIN
) (
   input  wire logic                             MCLK_IN,
   input  wire logic                             RST_IN,
   input  wire logic [NPIN-1:0]                  EXT_PIN_IN,
   input  wire logic [NPIN-1:0]                  EXT_EDGE_WR_IN,
   input  wire logic [NPIN-1:0]                  EXT_EDGE_WDATA_IN,
   input  wire logic [NSRC-1:0]                  SRC_EVENT_IN,
   input  wire logic [NSRC-1:0]                  SRC_PERIPH_IN,
   input  wire logic [NSRC-1:0]                  FLAG_CLR_IN,
   input  wire logic [NSRC-1:0]                  ENABLE_WDATA_IN,
   input  wire logic                             ENABLE_WR_IN,
   input  wire logic [NSRC-1:0]                  PRIO_WDATA_IN,
   input  wire logic                             PRIO_WR_IN,
   input  wire logic                             PRIO_MODE_WDATA_IN,
   input  wire logic                             PRIO_MODE_WR_IN,
   input  wire logic [1:0]                       CTRL_WDATA_IN,
   input  wire logic                             CTRL_WR_IN,
   input  wire logic                             RETURN_IRQ_IN,
   input  wire logic                             ACK_IN,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0]  RET_ADDR_IN,
   output logic [NSRC+NPIN-1:0]                  FLAG_OUT,
   output logic                                  PRIO_MODE_OUT,
   output logic                                  HIGH_EN_OUT,
   output logic                                  LOW_EN_OUT,
   output logic                                  IRQ_REQ_OUT,
   output logic [irq_prio_pkg::ADDR_W-1:0]       VECTOR_OUT,
   output logic                                  PUSH_OUT,
   output logic [irq_prio_pkg::ADDR_W-1:0]       PUSH_ADDR_OUT,
   output logic                                  LOAD_PC_OUT,
   output logic [1:0]                            LEVEL_OUT
);
   import irq_prio_pkg::*;
   localparam int NALL = NSRC + NPIN;
   localparam int LAT_LO = LAT_MIN_CYC;
   localparam int LAT_HI = LAT_MAX_CYC;

   // Source map: [NSRC-1:0] internal sources, top NPIN are the pins
   typedef struct packed {
      logic [NALL-1:0]   flag;
      logic [NALL-1:0]   en;
      logic [NALL-1:0]   prio;
      logic [NPIN-1:0]   edge_sel;
      logic              prio_mode;
      logic              gie_h;
      logic              gie_l;
      lvl_t              lvl;
      logic              req;
      logic              req_high;
      logic [ADDR_W-1:0] vec;
      logic              push;
      logic [ADDR_W-1:0] push_addr;
   } st_t;

   st_t q;
   st_t next_q;
   logic [NPIN-1:0] pin_ev;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         irq_edge_det u_det (
            .clk_in      (MCLK_IN),
            .rst_in      (RST_IN),
            .pin_in      (EXT_PIN_IN[gi]),
            .rise_sel_in (q.edge_sel[gi]),
            .event_out   (pin_ev[gi])
         );
      end
   endgenerate

   logic [NALL-1:0] events;
   logic [NALL-1:0] periph;
   logic [NALL-1:0] active;
   logic            any_high;
   logic            any_low;
   logic            any_compat;
   assign events = {pin_ev, SRC_EVENT_IN};
   assign periph = {{NPIN{1'b0}}, SRC_PERIPH_IN};
   assign active = q.flag & q.en;

   always_comb begin
      any_high   = 1'b0;
      any_low    = 1'b0;
      any_compat = 1'b0;
      for (int i = 0; i < NALL; i++) begin
         if (active[i] && q.prio[i]) begin
            any_high = 1'b1;
         end
         if (active[i] && !q.prio[i]) begin
            any_low = 1'b1;
         end
         // Priority bits play no part here
         if (active[i] && (!periph[i] || q.gie_l)) begin
            any_compat = 1'b1;
         end
      end
   end

   logic take_high;
   logic take_low;
   logic take_compat;
   always_comb begin
      take_high   = q.prio_mode && q.gie_h && any_high && !q.req;
      // High wins a tie; low stays pending
      take_low    = q.prio_mode && q.gie_l && any_low && !q.req &&
                    !take_high && (q.lvl == LVL_IDLE);
      take_compat = !q.prio_mode && q.gie_h && any_compat && !q.req;
   end

   always_comb begin
      next_q = q;
      // Set beats a same-cycle clear; enables never gate the flag
      for (int i = 0; i < NSRC; i++) begin
         next_q.flag[i] = events[i] | (q.flag[i] & ~FLAG_CLR_IN[i]);
      end
      for (int i = NSRC; i < NALL; i++) begin
         next_q.flag[i] = events[i] | q.flag[i];
      end
      if (ENABLE_WR_IN) begin
         next_q.en[NSRC-1:0] = ENABLE_WDATA_IN;
      end
      if (PRIO_WR_IN) begin
         next_q.prio[NSRC-1:0] = PRIO_WDATA_IN;
      end
      for (int j = 0; j < NPIN; j++) begin
         if (EXT_EDGE_WR_IN[j]) begin
            next_q.edge_sel[j] = EXT_EDGE_WDATA_IN[j];
         end
      end
      if (PRIO_MODE_WR_IN) begin
         next_q.prio_mode = PRIO_MODE_WDATA_IN;
      end
      if (CTRL_WR_IN) begin
         next_q.gie_h = CTRL_WDATA_IN[1];
         next_q.gie_l = CTRL_WDATA_IN[0];
      end
      next_q.push = 1'b0;
      if (q.req && ACK_IN) begin
         // Core takes the vector: stack return address, load the PC
         next_q.req       = 1'b0;
         next_q.push      = 1'b1;
         next_q.push_addr = RET_ADDR_IN;
         if (!q.prio_mode) begin
            next_q.gie_h = 1'b0;
            next_q.lvl   = LVL_LOW;
         end else if (q.req_high) begin
            next_q.gie_h = 1'b0;
            next_q.lvl   = (q.lvl == LVL_LOW) ? LVL_HNL : LVL_HIGH;
         end else begin
            next_q.gie_l = 1'b0;
            next_q.lvl   = LVL_LOW;
         end
      end else if (take_high) begin
         // Preempts a low routine since lvl is not consulted
         next_q.req      = 1'b1;
         next_q.req_high = 1'b1;
         next_q.vec      = VEC_HIGH;
      end else if (take_low) begin
         next_q.req      = 1'b1;
         next_q.req_high = 1'b0;
         next_q.vec      = VEC_LOW;
      end else if (take_compat) begin
         next_q.req      = 1'b1;
         next_q.req_high = 1'b1;
         next_q.vec      = VEC_HIGH;
      end else if (RETURN_IRQ_IN && !q.req) begin
         case (q.lvl)
            LVL_HIGH: begin
               next_q.gie_h = 1'b1;
               next_q.lvl   = LVL_IDLE;
            end
            LVL_HNL: begin
               next_q.gie_h = 1'b1;
               next_q.lvl   = LVL_LOW;
            end
            LVL_LOW: begin
               if (q.prio_mode) begin
                  next_q.gie_l = 1'b1;
               end else begin
                  next_q.gie_h = 1'b1;
               end
               next_q.lvl = LVL_IDLE;
            end
            default: begin
               if (q.prio_mode) begin
                  next_q.gie_l = 1'b1;
               end else begin
                  next_q.gie_h = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         q           <= '0;
         q.edge_sel  <= {NPIN{EDGE_SEL_RST}};
         q.prio_mode <= PRIO_MODE_RST;
         q.lvl       <= LVL_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign FLAG_OUT      = q.flag;
   assign PRIO_MODE_OUT = q.prio_mode;
   assign HIGH_EN_OUT   = q.gie_h;
   assign LOW_EN_OUT    = q.gie_l;
   assign IRQ_REQ_OUT   = q.req;
   assign VECTOR_OUT    = q.vec;
   assign PUSH_OUT      = q.push;
   assign PUSH_ADDR_OUT = q.push_addr;
   assign LOAD_PC_OUT   = q.push;
   assign LEVEL_OUT     = q.lvl;

   property p_high_vec;
      @(posedge MCLK_IN) disable iff (RST_IN)
      $rose(q.req) && q.req_high |-> q.vec == VEC_HIGH;
   endproperty
   a_high_vec: assert property (p_high_vec)
      else $error("high request with wrong vector");

   property p_low_vec;
      @(posedge MCLK_IN) disable iff (RST_IN)
      $rose(q.req) && !q.req_high |-> q.vec == VEC_LOW && q.prio_mode;
   endproperty
   a_low_vec: assert property (p_low_vec)
      else $error("low request with wrong vector or mode");

   property p_compat_vec;
      @(posedge MCLK_IN) disable iff (RST_IN)
      $rose(q.req) && !q.prio_mode |-> q.vec == VEC_HIGH;
   endproperty
   a_compat_vec: assert property (p_compat_vec)
      else $error("compat request not at high vector");

   property p_no_low_in_high;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (q.lvl == LVL_HIGH || q.lvl == LVL_HNL) |=> !($rose(q.req) && !q.req_high);
   endproperty
   a_no_low_in_high: assert property (p_no_low_in_high)
      else $error("low request during high routine");

   property p_clear_gie;
      @(posedge MCLK_IN) disable iff (RST_IN)
      q.req && ACK_IN && q.req_high |=> !q.gie_h && q.push;
   endproperty
   a_clear_gie: assert property (p_clear_gie)
      else $error("enable not cleared on acceptance");

   property p_push_addr;
      @(posedge MCLK_IN) disable iff (RST_IN)
      q.req && ACK_IN |=> q.push_addr == $past(RET_ADDR_IN);
   endproperty
   a_push_addr: assert property (p_push_addr)
      else $error("wrong return address pushed");

   property p_flag_set;
      @(posedge MCLK_IN) disable iff (RST_IN)
      SRC_EVENT_IN[0] |=> q.flag[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event did not set flag");

   property p_tie_high;
      @(posedge MCLK_IN) disable iff (RST_IN)
      q.prio_mode && q.gie_h && q.gie_l && any_high && any_low && !q.req
      |=> q.req && q.req_high && q.vec == VEC_HIGH;
   endproperty
   a_tie_high: assert property (p_tie_high)
      else $error("low won over high");

   property p_pin_latency;
      @(posedge MCLK_IN) disable iff (RST_IN)
      $rose(EXT_PIN_IN[0]) && q.edge_sel[0] && !EXT_EDGE_WR_IN[0]
      |-> ##[LAT_LO:LAT_HI] q.flag[NSRC];
   endproperty
   a_pin_latency: assert property (p_pin_latency)
      else $error("pin flag not set in time");

   property p_low_clear;
      @(posedge MCLK_IN) disable iff (RST_IN)
      q.prio_mode && q.req && ACK_IN && !q.req_high
      |=> !q.gie_l && q.push && q.lvl == LVL_LOW;
   endproperty
   a_low_clear: assert property (p_low_clear)
      else $error("low enable not cleared on acceptance");

   property p_ret_high;
      @(posedge MCLK_IN) disable iff (RST_IN)
      RETURN_IRQ_IN && !q.req && q.lvl == LVL_HIGH && !take_high
      |=> q.gie_h && q.lvl == LVL_IDLE;
   endproperty
   a_ret_high: assert property (p_ret_high)
      else $error("return from high routine did not re-enable");

   property p_ret_low;
      @(posedge MCLK_IN) disable iff (RST_IN)
      q.prio_mode && RETURN_IRQ_IN && !q.req && q.lvl == LVL_LOW
      && !take_high |=> q.gie_l && q.lvl == LVL_IDLE;
   endproperty
   a_ret_low: assert property (p_ret_low)
      else $error("return from low routine did not re-enable");
endmodule
`default_nettype wire

// >>> rtl/irq_prio_pkg.sv
package irq_prio_pkg;
   localparam int          ADDR_W      = 21;
   localparam int          NUM_SRC     = 8;
   localparam int          NUM_PIN     = 3;
   localparam logic [20:0] VEC_HIGH    = 21'h000008;
   localparam logic [20:0] VEC_LOW     = 21'h000018;
   localparam int          CTRL_GH_BIT = 7;
   localparam int          CTRL_GL_BIT = 6;
   localparam int          RST_PRIO_BIT = 7;
   localparam logic        PRIO_MODE_RST = 1'b0;
   localparam logic        EDGE_SEL_RST  = 1'b1;
   localparam int          LAT_MIN_CYC   = 3;
   localparam int          LAT_MAX_CYC   = 4;
   typedef enum logic [1:0] {
      LVL_IDLE = 2'b00,
      LVL_LOW  = 2'b01,
      LVL_HIGH = 2'b11,
      LVL_HNL  = 2'b10
   } lvl_t;
endpackage

// >>> rtl/irq_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
module irq_edge_det (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic pin_in,
   input  wire logic rise_sel_in,
   output logic      event_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic ev;
      logic [2:0] warm;
   } det_t;
   det_t q;
   det_t next_q;
   always_comb begin
      next_q    = q;
      next_q.s1 = pin_in;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.warm = {q.warm[1:0], 1'b1};
      // Quiet until the chain holds real samples, else a pin idling high
      // fakes a rising edge after reset; an edge that early is lost
      // Edge polarity chosen live; a select change alone fakes no edge but can drop one in flight
      next_q.ev = q.warm[2] &
                  (rise_sel_in ? (q.s2 & ~q.s3) : (~q.s2 & q.s3));
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign event_out = q.ev;
endmodule
`default_nettype wire

// >>> testbench/core_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_seq_model (
   input  wire logic        clk_in,
   input  wire logic        req_in,
   input  wire logic        slow_in,
   input  wire logic        push_in,
   input  wire logic        load_pc_in,
   input  wire logic [20:0] vector_in,
   output logic             ack_out,
   output logic [20:0]      ret_addr_out,
   output logic [20:0]      pc_out
);
   logic [1:0] stall;
   initial begin
      ack_out = 1'b0;
      ret_addr_out = 21'h000100;
      pc_out = 21'h000000;
      stall = 2'h0;
   end
   // A slow core spends two more cycles ending its current instruction
   always @(posedge clk_in) begin
      stall <= (req_in && !ack_out) ? stall + 2'h1 : 2'h0;
      ack_out <= req_in && !ack_out && (!slow_in || stall == 2'h2);
      if (push_in) ret_addr_out <= ret_addr_out + 21'h000004;
      if (load_pc_in) pc_out <= vector_in;
   end
endmodule
`default_nettype wire

// >>> testbench/two_level_interrupt_priority_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) \
   begin \
      checked++; \
      if ((a) !== (e)) begin \
         num_errors++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module two_level_interrupt_priority_ctrl_bench;
   import irq_prio_pkg::*;
   logic        clk, rst, mode_wr, mode_d, ctrl_wr, en_wr, prio_wr, ret;
   logic        ack, slow, pmode, hen, len, req, push, ldpc;
   logic [1:0]  ctrl_d, lvl;
   logic [2:0]  pin, edge_wr, edge_d;
   logic [7:0]  ev, periph, clr, en_d, prio_d;
   logic [10:0] flag;
   logic [20:0] ret_addr, pc, vec, push_addr;
   int          num_errors, checked, n;

   irq_prio_ctrl uut (
      .MCLK_IN            (clk),
      .RST_IN             (rst),
      .EXT_PIN_IN         (pin),
      .EXT_EDGE_WR_IN     (edge_wr),
      .EXT_EDGE_WDATA_IN  (edge_d),
      .SRC_EVENT_IN       (ev),
      .SRC_PERIPH_IN      (periph),
      .FLAG_CLR_IN        (clr),
      .ENABLE_WDATA_IN    (en_d),
      .ENABLE_WR_IN       (en_wr),
      .PRIO_WDATA_IN      (prio_d),
      .PRIO_WR_IN         (prio_wr),
      .PRIO_MODE_WDATA_IN (mode_d),
      .PRIO_MODE_WR_IN    (mode_wr),
      .CTRL_WDATA_IN      (ctrl_d),
      .CTRL_WR_IN         (ctrl_wr),
      .RETURN_IRQ_IN      (ret),
      .ACK_IN             (ack),
      .RET_ADDR_IN        (ret_addr),
      .FLAG_OUT           (flag),
      .PRIO_MODE_OUT      (pmode),
      .HIGH_EN_OUT        (hen),
      .LOW_EN_OUT         (len),
      .IRQ_REQ_OUT        (req),
      .VECTOR_OUT         (vec),
      .PUSH_OUT           (push),
      .PUSH_ADDR_OUT      (push_addr),
      .LOAD_PC_OUT        (ldpc),
      .LEVEL_OUT          (lvl)
   );
   core_seq_model partner (
      .clk_in       (clk),
      .req_in       (req),
      .slow_in      (slow),
      .push_in      (push),
      .load_pc_in   (ldpc),
      .vector_in    (vec),
      .ack_out      (ack),
      .ret_addr_out (ret_addr),
      .pc_out       (pc)
   );

   always #5 clk = ~clk;

   // Control bits change only through their strobes, never by a bulk move
   task automatic pulse(input int k, input logic [7:0] d);
      @(negedge clk);
      case (k)
         0: {en_wr, en_d} = {1'b1, d};
         1: {prio_wr, prio_d} = {1'b1, d};
         2: {mode_wr, mode_d} = {1'b1, d[0]};
         3: {ctrl_wr, ctrl_d} = {1'b1, d[1:0]};
         4: ev = d;
         5: clr = d;
         6: ret = 1'b1;
         default: {edge_wr, edge_d} = {3'b111, d[2:0]};
      endcase
      @(negedge clk);
      {en_wr, prio_wr, mode_wr, ctrl_wr, ret} = 5'h00;
      {ev, clr} = 16'h0000;
      edge_wr = 3'b000;
   endtask

   task automatic take(input logic [20:0] v, input logic [1:0] l,
                       input logic cl);
      int w;
      w = 0;
      while (push !== 1'b1 && w < 40) begin
         @(negedge clk);
         w++;
      end
      `CHK(push, 1'b1)
      `CHK(push_addr, ret_addr)
      if (cl) `CHK(lvl, l)
      repeat (2) @(negedge clk);
      `CHK(pc, v)
   endtask

   task automatic end_sim;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      {rst, mode_wr, mode_d, ctrl_wr, en_wr, prio_wr, ret, slow} = 8'h80;
      {ev, periph, clr, en_d, prio_d} = '0;
      {pin, edge_wr, edge_d} = '0;
      ctrl_d = 2'h0;
      num_errors = 0;
      checked = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      `CHK({pmode, hen, len, req, flag}, 15'h0000)
      pulse(0, 8'h03);
      pulse(1, 8'h03);
      periph = 8'h02;
      pulse(3, 8'h02);
      pulse(4, 8'h06);
      repeat (4) @(negedge clk);
      `CHK({req, flag[2:0]}, 4'h6)
      pulse(4, 8'h01);
      take(VEC_HIGH, 2'h0, 1'b0);
      `CHK({hen, len}, 2'b00)
      pulse(5, 8'h01);
      pulse(6, 8'h00);
      repeat (2) @(negedge clk);
      `CHK({hen, req}, 2'b10)
      pulse(3, 8'h03);
      take(VEC_HIGH, 2'h0, 1'b0);
      pulse(5, 8'h06);
      pulse(6, 8'h00);
      pulse(2, 8'h01);
      `CHK(pmode, 1'b1)
      pulse(1, 8'h01);
      pulse(4, 8'h02);
      take(VEC_LOW, LVL_LOW, 1'b1);
      `CHK({hen, len}, 2'b10)
      pulse(4, 8'h01);
      take(VEC_HIGH, LVL_HNL, 1'b1);
      `CHK({hen, len}, 2'b00)
      pulse(5, 8'h03);
      pulse(6, 8'h00);
      repeat (2) @(negedge clk);
      `CHK({hen, len, lvl}, {2'b10, LVL_LOW})
      pulse(6, 8'h00);
      repeat (2) @(negedge clk);
      `CHK({hen, len, lvl}, {2'b11, LVL_IDLE})
      pulse(3, 8'h01);
      pulse(4, 8'h01);
      repeat (4) @(negedge clk);
      `CHK(req, 1'b0)
      pulse(3, 8'h00);
      pulse(4, 8'h02);
      slow = 1'b1;
      pulse(3, 8'h03);
      take(VEC_HIGH, LVL_HIGH, 1'b1);
      repeat (6) @(negedge clk);
      `CHK({req, len, flag[1]}, 3'b011)
      pulse(5, 8'h01);
      pulse(6, 8'h00);
      take(VEC_LOW, LVL_LOW, 1'b1);
      pulse(5, 8'h02);
      pulse(6, 8'h00);
      pulse(0, 8'h02);
      pulse(4, 8'h01);
      repeat (4) @(negedge clk);
      `CHK({req, flag[0]}, 2'b01)
      pin = 3'b001;
      n = 0;
      while (flag[8] !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      `CHK(n inside {[3:4]}, 1'b1)
      pulse(7, 8'h00);
      pin = 3'b011;
      repeat (6) @(negedge clk);
      `CHK(flag[9], 1'b0)
      pin = 3'b001;
      repeat (6) @(negedge clk);
      `CHK(flag[9], 1'b1)
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      `CHK({pmode, hen, len, flag}, 14'h0000)
      end_sim;
   end

   // The whole sequence takes well under a thousand cycles
   initial begin
      #200000;
      num_errors++;
      end_sim;
   end
endmodule
`default_nettype wire
